// >>> common/asf_regs.vh
// constants for the alu status flag block
//
// What this block does
// RULE1: the flag register can be the source or destination operand of any instruction.
// RULE2: a flag-updating instruction aimed at the flag register drops its result and only updates flags.
// RULE3: clearing the flag register sets zero and leaves the other flags unchanged.
// RULE4: bit clear, bit set, nibble swap and the two moves leave all five flags alone.
// RULE5: the negative flag (bit 4) copies the top bit of the alu result.
// RULE6: the overflow flag (bit 3) is set when a signed result overflows into the sign bit.
// RULE7: the zero flag (bit 2) is set when the result is zero and cleared otherwise.
// RULE8: for the adds and subtracts the digit carry flag (bit 1) is the carry out of bit 3.
// RULE9: for the adds and subtracts the carry flag (bit 0) is the carry out of bit 7.
// RULE10: subtraction adds the two's complement, so carry and digit carry mean no borrow.
// RULE11: rotates load carry with the bit shifted out, bit 0 right and bit 7 left.
// RULE12: the three upper bits read zero and ignore writes; flag values after reset are not defined.
`ifndef ASF_REGS_VH
`define ASF_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ASF_OFS_FLAGS 8'h00
`define ASF_OFS_CTRL 8'h04
`define ASF_OFS_LAST 8'h08
`define ASF_OFS_COUNT 8'h0c

// ----------------------------------------
// flag positions and reset values
// ----------------------------------------
`define ASF_BIT_C 0
`define ASF_BIT_DC 1
`define ASF_BIT_Z 2
`define ASF_BIT_OV 3
`define ASF_BIT_N 4
`define ASF_FLAGS_RST 5'h00
`define ASF_CTRL_RST 1'b1

// ----------------------------------------
// instruction codes
// ----------------------------------------
`define ASF_OP_ADD_W_TO_FILE 4'h0
`define ASF_OP_ADD_LITERAL_TO_W 4'h1
`define ASF_OP_SUBTRACT_W_FROM_LITERAL 4'h2
`define ASF_OP_SUBTRACT_W_FROM_FILE 4'h3
`define ASF_OP_RRF 4'h4
`define ASF_OP_RLF 4'h5
`define ASF_OP_CLR 4'h6
`define ASF_OP_BCLR 4'h7
`define ASF_OP_BSET 4'h8
`define ASF_OP_SWAP 4'h9
`define ASF_OP_MOVE_FILE_TO_FILE 4'ha
`define ASF_OP_MOVE_W_TO_FILE 4'hb
`define ASF_OP_AND 4'hc
`define ASF_OP_IOR 4'hd
`define ASF_OP_XOR 4'he
`define ASF_OP_MOVF 4'hf

// ----------------------------------------
// bus answers
// ----------------------------------------
`define ASF_RESP_OKAY 2'h0
`define ASF_RESP_SLVERR 2'h2

`endif

// >>> rtl/asf_adder.v
// eight bit adder with nibble carry and signed overflow
`timescale 1ns/1ps
module asf_adder #(
  parameter WIDTH = 8
) (
  // operands
  input wire [WIDTH-1:0] a_i,
  input wire [WIDTH-1:0] b_i,
  input wire cin_i,
  // results
  output wire [WIDTH-1:0] sum_o,
  output wire dcout_o,
  output wire cout_o,
  output wire ov_o
);
  wire [4:0] low;
  wire [WIDTH:0] full;

  // RULE8: nibble carry
  assign low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
  assign dcout_o = low[4];
  // RULE9: carry from msb
  assign full = {1'b0, a_i} + {1'b0, b_i} + {{WIDTH{1'b0}}, cin_i};
  assign sum_o = full[WIDTH-1:0];
  assign cout_o = full[WIDTH];
  // RULE6: sign bit overflow
  assign ov_o = (a_i[WIDTH-1] == b_i[WIDTH-1]) && (sum_o[WIDTH-1] != a_i[WIDTH-1]);
endmodule

// >>> rtl/asf_rotate.v
// rotate through carry, either direction
`timescale 1ns/1ps
module asf_rotate #(
  parameter WIDTH = 8
) (
  // operand
  input wire [WIDTH-1:0] a_i,
  input wire cin_i,
  input wire left_i,
  // result
  output wire [WIDTH-1:0] res_o,
  output wire cout_o
);
  assign res_o = left_i ? {a_i[WIDTH-2:0], cin_i} : {cin_i, a_i[WIDTH-1:1]};
  // RULE11: shifted-out bit to carry
  assign cout_o = left_i ? a_i[WIDTH-1] : a_i[0];
endmodule

// >>> rtl/asf_top.v
// alu status flag register with core port and axi4-lite access
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "asf_regs.vh"
module asf_top #(
  parameter ADDR_W = 8,
  parameter CNT_W = 16
) (
  // clock and reset
  input wire CLK_SYS_I,
  input wire RESET_N_I,
  // axi4-lite write
  input wire [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire S_AXI_AWVALID_I,
  output wire S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output wire S_AXI_WREADY_O,
  output wire [1:0] S_AXI_BRESP_O,
  output wire S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  // axi4-lite read
  input wire [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire S_AXI_ARVALID_I,
  output wire S_AXI_ARREADY_O,
  output wire [31:0] S_AXI_RDATA_O,
  output wire [1:0] S_AXI_RRESP_O,
  output wire S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  // core execute request
  input wire EXEC_VALID_I,
  input wire [3:0] EXEC_OP_I,
  input wire [7:0] EXEC_SRC_I,
  input wire [7:0] EXEC_W_I,
  input wire [2:0] EXEC_BIT_I,
  input wire EXEC_SRC_FLAGS_I,
  input wire EXEC_DEST_FLAGS_I,
  // core execute answer
  output wire [7:0] RESULT_O,
  output wire RESULT_VALID_O,
  output wire RESULT_WRITE_O,
  output wire [7:0] FLAGS_O
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [4:0] flags_q;
  reg [4:0] flags_d;
  reg ctrl_en_q;
  reg ctrl_en_d;
  reg [7:0] res_q;
  reg [7:0] res_d;
  reg res_valid_q;
  reg res_write_q;
  reg res_write_d;
  reg [3:0] last_op_q;
  reg last_dest_q;
  reg [CNT_W-1:0] count_q;
  reg aw_full_q;
  reg aw_full_d;
  reg [ADDR_W-1:0] aw_addr_q;
  reg w_full_q;
  reg w_full_d;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg awready_q;
  reg wready_q;
  reg bvalid_q;
  reg bvalid_d;
  reg [1:0] bresp_q;
  reg [1:0] bresp_d;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  // ----------------------------------------
  // operand select and arithmetic units
  // ----------------------------------------
  wire exec_take;
  wire [7:0] src;
  wire is_sub;
  wire [7:0] add_b;
  wire [7:0] add_sum;
  wire add_dc;
  wire add_c;
  wire add_ov;
  wire [7:0] rot_res;
  wire rot_c;

  // requests are dropped while software has execution disabled
  assign exec_take = EXEC_VALID_I && ctrl_en_q;
  // RULE1: flags as source operand
  assign src = EXEC_SRC_FLAGS_I ? {3'h0, flags_q} : EXEC_SRC_I;
  assign is_sub = (EXEC_OP_I == `ASF_OP_SUBTRACT_W_FROM_LITERAL) || (EXEC_OP_I == `ASF_OP_SUBTRACT_W_FROM_FILE);
  // RULE10: subtract via two's complement
  assign add_b = is_sub ? ~EXEC_W_I : EXEC_W_I;

  asf_adder #(
    .WIDTH(8)
  ) u_adder (
    .a_i(src),
    .b_i(add_b),
    .cin_i(is_sub),
    .sum_o(add_sum),
    .dcout_o(add_dc),
    .cout_o(add_c),
    .ov_o(add_ov)
  );

  asf_rotate #(
    .WIDTH(8)
  ) u_rotate (
    .a_i(src),
    .cin_i(flags_q[`ASF_BIT_C]),
    .left_i(EXEC_OP_I == `ASF_OP_RLF),
    .res_o(rot_res),
    .cout_o(rot_c)
  );

  // ----------------------------------------
  // instruction result and flag update
  // ----------------------------------------
  reg [7:0] alu_res;
  reg [4:0] upd;
  reg affects;

  always @*
  begin
    alu_res = 8'h00;
    upd = flags_q;
    affects = 1'b1;
    case (EXEC_OP_I)
      `ASF_OP_ADD_W_TO_FILE, `ASF_OP_ADD_LITERAL_TO_W, `ASF_OP_SUBTRACT_W_FROM_LITERAL, `ASF_OP_SUBTRACT_W_FROM_FILE:
      begin
        alu_res = add_sum;
        upd[`ASF_BIT_OV] = add_ov;
        // RULE8: digit carry on add/sub
        upd[`ASF_BIT_DC] = add_dc;
        // RULE9: carry on add/sub
        upd[`ASF_BIT_C] = add_c;
      end
      `ASF_OP_RRF, `ASF_OP_RLF:
      begin
        alu_res = rot_res;
        // RULE11: rotate loads carry
        upd[`ASF_BIT_C] = rot_c;
      end
      // RULE3: clear only raises zero
      `ASF_OP_CLR:
      begin
        alu_res = 8'h00;
      end
      `ASF_OP_AND:
      begin
        alu_res = src & EXEC_W_I;
      end
      `ASF_OP_IOR:
      begin
        alu_res = src | EXEC_W_I;
      end
      `ASF_OP_XOR:
      begin
        alu_res = src ^ EXEC_W_I;
      end
      `ASF_OP_MOVF:
      begin
        alu_res = src;
      end
      // RULE4: these leave every flag alone
      `ASF_OP_BCLR:
      begin
        alu_res = src & ~(8'h01 << EXEC_BIT_I);
        affects = 1'b0;
      end
      `ASF_OP_BSET:
      begin
        alu_res = src | (8'h01 << EXEC_BIT_I);
        affects = 1'b0;
      end
      `ASF_OP_SWAP:
      begin
        alu_res = {src[3:0], src[7:4]};
        affects = 1'b0;
      end
      `ASF_OP_MOVE_FILE_TO_FILE:
      begin
        alu_res = src;
        affects = 1'b0;
      end
      `ASF_OP_MOVE_W_TO_FILE:
      begin
        alu_res = EXEC_W_I;
        affects = 1'b0;
      end
      default:
      begin
        alu_res = src;
        affects = 1'b0;
      end
    endcase
    if (affects)
    begin
      // RULE5: negative from msb; clear keeps it, so only zero moves
      if (EXEC_OP_I != `ASF_OP_CLR)
      begin
        upd[`ASF_BIT_N] = alu_res[7];
      end
      // RULE7: zero detect
      upd[`ASF_BIT_Z] = (alu_res == 8'h00);
    end
  end

  // ----------------------------------------
  // bus write decode
  // ----------------------------------------
  wire do_write;
  wire wr_flags;
  wire wr_ctrl;
  wire wr_known;

  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_flags = aw_addr_q[ADDR_W-1:2] == `ASF_OFS_FLAGS >> 2;
  assign wr_ctrl = aw_addr_q[ADDR_W-1:2] == `ASF_OFS_CTRL >> 2;
  assign wr_known = wr_flags || wr_ctrl
    || (aw_addr_q[ADDR_W-1:2] == `ASF_OFS_LAST >> 2)
    || (aw_addr_q[ADDR_W-1:2] == `ASF_OFS_COUNT >> 2);

  always @*
  begin
    flags_d = flags_q;
    ctrl_en_d = ctrl_en_q;
    res_d = alu_res;
    res_write_d = 1'b1;
    if (exec_take && EXEC_DEST_FLAGS_I && affects)
    begin
      // RULE2: result dropped, flags only
      // RULE3: clear leaves 000u u1uu
      flags_d = upd;
      res_write_d = 1'b0;
    end
    else if (exec_take && EXEC_DEST_FLAGS_I)
    begin
      // RULE1: flags as destination
      // RULE12: upper bits not stored
      flags_d = alu_res[4:0];
    end
    else if (exec_take)
    begin
      flags_d = upd;
    end
    else if (do_write && wr_flags && w_strb_q[0])
    begin
      // core updates win over a colliding bus write
      flags_d = w_data_q[4:0];
    end
    if (do_write && wr_ctrl && w_strb_q[0])
    begin
      ctrl_en_d = w_data_q[0];
    end
  end

  // ----------------------------------------
  // bus write channel control
  // ----------------------------------------
  always @*
  begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (S_AXI_AWVALID_I && awready_q)
    begin
      aw_full_d = 1'b1;
    end
    if (S_AXI_WVALID_I && wready_q)
    begin
      w_full_d = 1'b1;
    end
    if (do_write)
    begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_known ? `ASF_RESP_OKAY : `ASF_RESP_SLVERR;
    end
    else if (bvalid_q && S_AXI_BREADY_I)
    begin
      bvalid_d = 1'b0;
    end
  end

  // ----------------------------------------
  // bus read decode
  // ----------------------------------------
  reg [31:0] rd_word;
  reg rd_known;

  always @*
  begin
    rd_word = 32'h0000_0000;
    rd_known = 1'b1;
    case (S_AXI_ARADDR_I[ADDR_W-1:2])
      `ASF_OFS_FLAGS >> 2:
      begin
        // RULE12: upper bits read zero
        rd_word = {27'h000_0000, flags_q};
      end
      `ASF_OFS_CTRL >> 2:
      begin
        rd_word = {31'h0000_0000, ctrl_en_q};
      end
      `ASF_OFS_LAST >> 2:
      begin
        rd_word = {18'h0_0000, last_dest_q, res_write_q, last_op_q, res_q};
      end
      `ASF_OFS_COUNT >> 2:
      begin
        rd_word = {{(32 - CNT_W){1'b0}}, count_q};
      end
      default:
      begin
        rd_known = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // flag reset value is arbitrary; software must not rely on it
  always @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      flags_q <= `ASF_FLAGS_RST;
      ctrl_en_q <= `ASF_CTRL_RST;
      res_q <= 8'h00;
      res_valid_q <= 1'b0;
      res_write_q <= 1'b0;
      last_op_q <= 4'h0;
      last_dest_q <= 1'b0;
      count_q <= {CNT_W{1'b0}};
    end
    else
    begin
      flags_q <= flags_d;
      ctrl_en_q <= ctrl_en_d;
      res_valid_q <= exec_take;
      if (exec_take)
      begin
        res_q <= res_d;
        res_write_q <= res_write_d;
        last_op_q <= EXEC_OP_I;
        last_dest_q <= EXEC_DEST_FLAGS_I;
        count_q <= count_q + {{(CNT_W - 1){1'b0}}, 1'b1};
      end
    end
  end

  // one write and one read in flight; ready drops while a slot is held
  always @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `ASF_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ASF_RESP_OKAY;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awready_q <= !aw_full_d && !bvalid_d;
      wready_q <= !w_full_d && !bvalid_d;
      if (S_AXI_AWVALID_I && awready_q)
      begin
        aw_addr_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && wready_q)
      begin
        w_data_q <= S_AXI_WDATA_I;
        w_strb_q <= S_AXI_WSTRB_I;
      end
      if (S_AXI_ARVALID_I && arready_q)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_known ? `ASF_RESP_OKAY : `ASF_RESP_SLVERR;
      end
      else if (rvalid_q && S_AXI_RREADY_I)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign S_AXI_AWREADY_O = awready_q;
  assign S_AXI_WREADY_O = wready_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_ARREADY_O = arready_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign RESULT_O = res_q;
  assign RESULT_VALID_O = res_valid_q;
  assign RESULT_WRITE_O = res_write_q;
  assign FLAGS_O = {3'h0, flags_q};
endmodule

// >>> test/asf_top_sva.sv
// concurrent checks on the flag block core port
`timescale 1ns/1ps
module asf_top_sva (
  // clock and reset
  input wire CLK_SYS_I,
  input wire RESET_N_I,
  // core request
  input wire EXEC_VALID_I,
  input wire [3:0] EXEC_OP_I,
  input wire [7:0] EXEC_SRC_I,
  input wire [7:0] EXEC_W_I,
  input wire EXEC_SRC_FLAGS_I,
  input wire EXEC_DEST_FLAGS_I,
  // core answer
  input wire [7:0] RESULT_O,
  input wire RESULT_VALID_O,
  input wire RESULT_WRITE_O,
  input wire [7:0] FLAGS_O
);
  // ----------------------------------------
  // operands of the instruction now answered
  // ----------------------------------------
  reg [7:0] a_q;
  reg [7:0] w_q;
  reg [7:0] fl_q;
  reg [3:0] op_q;
  reg df_q;
  always @(posedge CLK_SYS_I)
  begin
    a_q <= EXEC_SRC_FLAGS_I ? FLAGS_O : EXEC_SRC_I;
    w_q <= EXEC_W_I;
    fl_q <= FLAGS_O;
    op_q <= EXEC_OP_I;
    df_q <= EXEC_DEST_FLAGS_I;
  end
  // subtract as add of the inverse plus one, so carry means no borrow
  wire [8:0] sum_w = {1'b0, a_q} + {1'b0, w_q};
  wire [8:0] dif_w = {1'b0, a_q} + {1'b0, ~w_q} + 9'h001;
  wire [4:0] dsum_w = {1'b0, a_q[3:0]} + {1'b0, w_q[3:0]};
  wire [4:0] ddif_w = {1'b0, a_q[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
  wire is_add = (op_q == 4'h0) || (op_q == 4'h1);
  wire is_sub = (op_q == 4'h2) || (op_q == 4'h3);
  wire fop = (op_q <= 4'h6) || (op_q >= 4'hc);
  wire nz = fop && (op_q != 4'h6);
  wire rv = RESULT_VALID_O;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  upper_bits_zero_a: assert property (FLAGS_O[7:5] == 3'h0)
    else $error("flag upper bits not zero");
  answer_cause_a: assert property (rv |-> $past(EXEC_VALID_I))
    else $error("answer without request");
  flag_dest_drop_a: assert property (rv && df_q && fop |-> !RESULT_WRITE_O)
    else $error("result kept for flag destination");
  clear_sets_zero_a: assert property (rv && op_q == 4'h6 |-> FLAGS_O[4:0] == (fl_q[4:0] | 5'h04))
    else $error("clear gave wrong flags");
  no_flag_ops_a: assert property (rv && !fop && !df_q |-> FLAGS_O == fl_q)
    else $error("flags moved on a quiet op");
  neg_flag_a: assert property (rv && nz |-> FLAGS_O[4] == RESULT_O[7])
    else $error("negative flag wrong");
  zero_flag_a: assert property (rv && nz |-> FLAGS_O[2] == (RESULT_O == 8'h00))
    else $error("zero flag wrong");
  add_overflow_a: assert property (rv && is_add |->
    FLAGS_O[3] == (a_q[7] == w_q[7] && sum_w[7] != a_q[7]))
    else $error("overflow flag wrong");
  add_carries_a: assert property (rv && is_add |-> FLAGS_O[1:0] == {dsum_w[4], sum_w[8]})
    else $error("add carries wrong");
  sub_borrow_a: assert property (rv && is_sub |->
    FLAGS_O[1:0] == {ddif_w[4], dif_w[8]} && RESULT_O == dif_w[7:0])
    else $error("subtract borrow wrong");
  rot_carry_a: assert property (rv && (op_q == 4'h4 || op_q == 4'h5) |->
    FLAGS_O[0] == (op_q[0] ? a_q[7] : a_q[0]))
    else $error("rotate carry wrong");
endmodule

bind asf_top asf_top_sva asf_top_sva_inst (
  .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .EXEC_VALID_I(EXEC_VALID_I),
  .EXEC_OP_I(EXEC_OP_I), .EXEC_SRC_I(EXEC_SRC_I), .EXEC_W_I(EXEC_W_I),
  .EXEC_SRC_FLAGS_I(EXEC_SRC_FLAGS_I), .EXEC_DEST_FLAGS_I(EXEC_DEST_FLAGS_I),
  .RESULT_O(RESULT_O), .RESULT_VALID_O(RESULT_VALID_O),
  .RESULT_WRITE_O(RESULT_WRITE_O), .FLAGS_O(FLAGS_O)
);

// >>> test/asf_core_model.sv
// core datapath model that issues one instruction at a time
`timescale 1ns/1ps
module asf_core_model (
  // clock
  input wire clk_i,
  // request
  output reg exec_valid_o = 1'b0,
  output reg [3:0] exec_op_o = 4'h0,
  output reg [7:0] exec_src_o = 8'h00,
  output reg [7:0] exec_w_o = 8'h00,
  output reg [2:0] exec_bit_o = 3'h0,
  output reg exec_sf_o = 1'b0,
  output reg exec_df_o = 1'b0
);
  task issue(input [3:0] op, input [7:0] s, input [7:0] w, input [2:0] bn,
    input sf, input df);
  begin
    @(posedge clk_i);
    exec_valid_o <= 1'b1;
    exec_op_o <= op;
    exec_src_o <= s;
    exec_w_o <= w;
    exec_bit_o <= bn;
    exec_sf_o <= sf;
    exec_df_o <= df;
    @(posedge clk_i);
    exec_valid_o <= 1'b0;
    // stale operands would hide a design that samples late
    exec_src_o <= ~s;
    exec_w_o <= ~w;
    #1;
  end
  endtask
endmodule

// >>> test/asf_top_bench.sv
// bench for the alu status flag block
`timescale 1ns/1ps
`include "asf_regs.vh"
`define CHK(a, b) \
  begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
module asf_top_bench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'h0;
  reg awvalid = 1'b0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, ev, esf, edf, rvld, rwr;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] eop;
  wire [7:0] esrc, ew, res, flags;
  wire [2:0] ebit;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  reg [31:0] rd;
  reg [1:0] rsp;
  reg [7:0] nf_res [0:4] = '{8'h58, 8'h5a, 8'ha5, 8'h5a, 8'h3c};
  initial forever #20 clk = ~clk;
  asf_top asf_top_inst (
    .CLK_SYS_I(clk), .RESET_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .EXEC_VALID_I(ev), .EXEC_OP_I(eop), .EXEC_SRC_I(esrc), .EXEC_W_I(ew),
    .EXEC_BIT_I(ebit), .EXEC_SRC_FLAGS_I(esf), .EXEC_DEST_FLAGS_I(edf),
    .RESULT_O(res), .RESULT_VALID_O(rvld), .RESULT_WRITE_O(rwr), .FLAGS_O(flags)
  );
  asf_core_model asf_core_model_inst (
    .clk_i(clk), .exec_valid_o(ev), .exec_op_o(eop), .exec_src_o(esrc),
    .exec_w_o(ew), .exec_bit_o(ebit), .exec_sf_o(esf), .exec_df_o(edf)
  );
  // ----------------------------------------
  // bus and core tasks
  // ----------------------------------------
  task results;
  begin
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task axw(input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    rsp = bresp;
  end
  endtask
  task axr(input [7:0] a);
  begin
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
  end
  endtask
  task ex(input [3:0] op, input [7:0] s, input [7:0] w, input sf, input df,
    input [7:0] er, input [4:0] ef, input ewr);
  begin
    asf_core_model_inst.issue(op, s, w, 3'h1, sf, df);
    `CHK(rvld, 1'b1)
    `CHK(res, er)
    `CHK(flags, {3'h0, ef})
    `CHK(rwr, ewr)
  end
  endtask
  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      results;
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    axr(8'h10);
    `CHK(rsp, `ASF_RESP_SLVERR)
    axw(`ASF_OFS_FLAGS, 32'hffff_ffff);
    `CHK(rsp, `ASF_RESP_OKAY)
    axr(`ASF_OFS_FLAGS);
    `CHK(rd, 32'h0000_001f)
    axw(`ASF_OFS_FLAGS, 32'h0);
    ex(`ASF_OP_ADD_W_TO_FILE, 8'h0f, 8'h01, 0, 0, 8'h10, 5'h02, 1);
    ex(`ASF_OP_ADD_LITERAL_TO_W, 8'h80, 8'h80, 0, 0, 8'h00, 5'h0d, 1);
    ex(`ASF_OP_ADD_W_TO_FILE, 8'h7f, 8'h01, 0, 0, 8'h80, 5'h1a, 1);
    ex(`ASF_OP_SUBTRACT_W_FROM_FILE, 8'h05, 8'h03, 0, 0, 8'h02, 5'h03, 1);
    ex(`ASF_OP_SUBTRACT_W_FROM_LITERAL, 8'h03, 8'h05, 0, 0, 8'hfe, 5'h10, 1);
    ex(`ASF_OP_CLR, 8'h00, 8'h00, 0, 1, 8'h00, 5'h14, 0);
    ex(`ASF_OP_RRF, 8'h01, 8'h00, 0, 0, 8'h00, 5'h05, 1);
    ex(`ASF_OP_RLF, 8'h80, 8'h00, 0, 0, 8'h01, 5'h01, 1);
    ex(`ASF_OP_CLR, 8'h00, 8'h00, 0, 1, 8'h00, 5'h05, 0);
    ex(`ASF_OP_ADD_W_TO_FILE, 8'h0f, 8'h01, 0, 1, 8'h10, 5'h02, 0);
    for (int i = 0; i < 5; i++)
      ex(`ASF_OP_BCLR + i, 8'h5a, 8'h3c, 0, 0, nf_res[i], 5'h02, 1);
    ex(`ASF_OP_MOVE_W_TO_FILE, 8'h00, 8'h13, 0, 1, 8'h13, 5'h13, 1);
    ex(`ASF_OP_MOVF, 8'h00, 8'h00, 1, 0, 8'h13, 5'h03, 1);
    ex(`ASF_OP_AND, 8'hf0, 8'h0f, 0, 0, 8'h00, 5'h07, 1);
    axr(`ASF_OFS_FLAGS);
    `CHK(rd, 32'h0000_0007)
    axr(`ASF_OFS_LAST);
    `CHK(rd, 32'h0000_1c00)
    axr(`ASF_OFS_COUNT);
    `CHK(rd, 32'h0000_0012)
    // execution disabled: the request must leave no trace
    axw(`ASF_OFS_CTRL, 32'h0);
    `CHK(rsp, `ASF_RESP_OKAY)
    asf_core_model_inst.issue(`ASF_OP_ADD_W_TO_FILE, 8'h01, 8'h01, 3'h0, 1'b0, 1'b0);
    `CHK(rvld, 1'b0)
    `CHK(flags, 8'h07)
    results;
  end
endmodule
